// ===== cafc_consts.vh
// Constants for the CAN acceptance filter configuration block.
// Included by the filter top, its monitor and the bench.
`ifndef CAFC_CONSTS_VH
`define CAFC_CONSTS_VH

// Register index map, word addresses on the plain register port
`define CAFC_ADDR_W 6
`define CAFC_CTRL0_ADDR 6'h00
`define CAFC_CTRL1_ADDR 6'h01
`define CAFC_CTRL2_ADDR 6'h02
`define CAFC_CTRL3_ADDR 6'h03
`define CAFC_MASK0_ADDR 6'h04
`define CAFC_STAT_ADDR 6'h08
`define CAFC_FID0_ADDR 6'h10
`define CAFC_FID_BLK 2'h1

// Filter control byte lane fields
`define CAFC_LANE_W 8
`define CAFC_EN_BIT 7
`define CAFC_MSEL_HI 6
`define CAFC_MSEL_LO 5
`define CAFC_FSEL_HI 4
`define CAFC_FSEL_LO 0

// Filter identifier register fields
`define CAFC_SID_HI 31
`define CAFC_SID_LO 21
`define CAFC_UNIMP_HI 20
`define CAFC_EXTENDED_SELECT_BIT 19
`define CAFC_UNIMP_LO 18
`define CAFC_EID_HI 17
`define CAFC_EID_LO 0
`define CAFC_FID_WMASK 32'hFFEBFFFF

// Reset values
`define CAFC_CTRL_RST 32'h00000000
`define CAFC_MASK_RST 32'h00000000

`endif

// ===== cafc_engine_model.sv
// Protocol engine stand-in: one received id per clock while valid.
// Caller enters send just after a rising edge.
module cafc_engine_model (
    input logic clk_sys,
    output logic rxValid = 1'h0,
    output logic rxExtended = 1'h0,
    output logic [10:0] rxStdId = 11'h000,
    output logic [17:0] rxExtId = 18'h00000
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle cycles show inverted ids, never a stale copy
    task send(input logic v, input logic e, input logic [10:0] s, input logic [17:0] x);
        rxValid <= v;
        rxExtended <= v ? e : ~rxExtended;
        rxStdId <= v ? s : ~rxStdId;
        rxExtId <= v ? x : ~rxExtId;
        @(posedge clk_sys);
    endtask
endmodule

// ===== cafc_filter_monitor.sv
// Checker for the filter top: match timing, enables, fifo steering, readback.
// Sees only top ports; assumes control is never written beside rxValid.
`include "cafc_consts.vh"
module cafc_filter_monitor #(
    parameter FIFO_W = 5
) (
    input logic clk_sys,
    input logic arst_n,
    input logic [`CAFC_ADDR_W-1:0] regAddr,
    input logic [31:0] regWrData,
    input logic regWrStb,
    input logic regRdStb,
    input logic [31:0] regRdData,
    input logic rxValid,
    input logic matchValid,
    input logic matchHit,
    input logic [3:0] matchFilter,
    input logic [FIFO_W-1:0] matchFifo
);
    logic [3:0][31:0] ctrlSh;
    logic [5:0] rdA;
    logic [15:0] en;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrlSh <= '0;
            rdA <= 6'h00;
        end else begin
            rdA <= regAddr;
            if (regWrStb && regAddr < 6'h04)
                ctrlSh[regAddr[1:0]] <= regWrData;
        end
    end
    always_comb begin
        for (int i = 0; i < 16; i++)
            en[i] = ctrlSh[i / 4][(i % 4) * 8 + 7];
    end
    a_match_latency: assert property (rxValid |=> matchValid)
        else $error("match result missing");
    a_match_spurious: assert property (!rxValid |=> !matchValid)
        else $error("match result without id");
    a_hit_needs_en: assert property (matchValid && matchHit |-> en[matchFilter])
        else $error("hit on disabled filter");
    a_all_off_miss: assert property (rxValid && en == 16'h0000 |=> !matchHit)
        else $error("hit with all filters off");
    a_fifo_from_lane: assert property (matchValid && matchHit
        |-> matchFifo == ctrlSh[matchFilter[3:2]][matchFilter[1:0] * 8 +: FIFO_W])
        else $error("fifo select wrong");
    a_unimpl_zero: assert property (regRdStb && regAddr[5:4] == 2'h1
        |=> regRdData[20] == 1'h0 && regRdData[18] == 1'h0)
        else $error("unimplemented bits set");
    a_result_hold: assert property (!rxValid
        |=> $stable({matchHit, matchFilter, matchFifo}))
        else $error("match result moved");
    a_ctrl_readback: assert property (regRdStb && regAddr < 6'h04
        |=> regRdData == ctrlSh[rdA[1:0]])
        else $error("control readback wrong");
endmodule
bind cafc_filter_top cafc_filter_monitor #(.FIFO_W(FIFO_W)) u_mon (.clk_sys(clk_sys),
    .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .rxValid(rxValid),
    .matchValid(matchValid), .matchHit(matchHit), .matchFilter(matchFilter),
    .matchFifo(matchFifo));

// ===== cafc_filter_top.v
// CAN acceptance filter configuration and matching.
// Assumes a plain register port and a protocol engine giving one id per pulse.
//
// Chosen here: strobed register access and the placing of the registers.
`include "cafc_consts.vh"

// Operation
// RULE1: A filter whose enable bit is clear matches nothing.
// RULE2: The two-bit mask select picks acceptance mask 0 to 3 for the filter.
// RULE3: A matching message is steered to the FIFO given by the filter's five-bit select.
// RULE4: Each control word holds four filters, one per byte lane, enable at the lane top.
// RULE5: Identifier bits 31-21 hold the standard identifier each received bit must equal.
// RULE6: Identifier bit 19 chooses extended-only or standard-only matching.
// RULE7: Identifier bits 17-0 hold the extended identifier each received bit must equal.
// RULE8: Identifier bits 20 and 18 read zero and ignore writes.
// RULE9: Writes to an identifier register are ignored while its filter is enabled.
// RULE10: Control fields and extended select clear at reset; identifier bits do not.
// RULE11: Sixteen identifier registers, 0-15, pair with same-numbered control fields.
// RULE12: A filter matches when masked id bits agree and the frame format agrees.
module cafc_filter_top #(
    parameter NUM_FILT = 16,
    parameter NUM_MASK = 4,
    parameter FIFO_W = 5
) (
    input wire clk_sys,
    input wire arst_n,
    input wire [`CAFC_ADDR_W-1:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    output reg [31:0] regRdData,
    input wire rxValid,
    input wire rxExtended,
    input wire [10:0] rxStdId,
    input wire [17:0] rxExtId,
    output reg matchValid,
    output reg matchHit,
    output reg [3:0] matchFilter,
    output reg [FIFO_W-1:0] matchFifo
);
    localparam NCTRL = NUM_FILT / 4;

    // Reset release
    reg rstSync1_ff;
    reg rstSync2_ff;
    wire rst_n;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1_ff <= 1'b0;
            rstSync2_ff <= 1'b0;
        end else begin
            rstSync1_ff <= 1'b1;
            rstSync2_ff <= rstSync1_ff;
        end
    end
    assign rst_n = rstSync2_ff;

    // Register storage
    reg [31:0] ctrl_ff [0:NCTRL-1];
    reg [31:0] mask_ff [0:NUM_MASK-1];
    reg [NUM_FILT-1:0] exSel_ff;
    reg [NUM_FILT-1:0] hitLast_ff;
    reg [15:0] hitCount_ff;

    wire [NUM_FILT-1:0] filtEn;
    wire [NUM_FILT*2-1:0] filtMsel;
    wire [NUM_FILT*FIFO_W-1:0] filtFsel;
    wire [NUM_FILT*32-1:0] idWords;
    wire [31:0] idRdData;

    // Decode
    wire isCtrl = (regAddr[`CAFC_ADDR_W-1:2] == `CAFC_CTRL0_ADDR >> 2);
    wire isMask = (regAddr[`CAFC_ADDR_W-1:2] == `CAFC_MASK0_ADDR >> 2);
    wire isStat = (regAddr == `CAFC_STAT_ADDR);
    wire isFid = (regAddr[`CAFC_ADDR_W-1:4] == `CAFC_FID_BLK);
    wire [3:0] fidIdx = regAddr[3:0];
    wire [1:0] subIdx = regAddr[1:0];

    // Identifier writes only while the filter is disabled
    wire fidWr = regWrStb && isFid && !filtEn[fidIdx]; // RULE9

    cafc_id_store #(
        .NUM(NUM_FILT),
        .IDX_W(4)
    ) uIdStore (
        .clk_sys(clk_sys),
        .wrEn(fidWr),
        .wrIdx(fidIdx),
        .wrData(regWrData & `CAFC_FID_WMASK), // RULE8
        .rdIdx(fidIdx),
        .rdData(idRdData),
        .allWords(idWords)
    );

    // Control, mask and extended select registers
    integer i;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < NCTRL; i = i + 1) begin
                ctrl_ff[i] <= `CAFC_CTRL_RST; // RULE10
            end
            for (i = 0; i < NUM_MASK; i = i + 1) begin
                mask_ff[i] <= `CAFC_MASK_RST;
            end
            exSel_ff <= {NUM_FILT{1'b0}}; // RULE10
        end else begin
            if (regWrStb && isCtrl) begin
                ctrl_ff[subIdx] <= regWrData;
            end
            if (regWrStb && isMask) begin
                mask_ff[subIdx] <= regWrData & `CAFC_FID_WMASK;
            end
            if (fidWr) begin
                exSel_ff[fidIdx] <= regWrData[`CAFC_EXTENDED_SELECT_BIT]; // RULE6
            end
        end
    end

    // Read path, data one cycle after the strobe
    reg rdCtrl_ff;
    reg rdFid_ff;
    reg [3:0] rdIdx_ff;
    reg [31:0] rdOther_ff;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdCtrl_ff <= 1'b0;
            rdFid_ff <= 1'b0;
            rdIdx_ff <= 4'h0;
            rdOther_ff <= 32'h00000000;
        end else begin
            rdFid_ff <= regRdStb && isFid;
            rdCtrl_ff <= regRdStb && !isFid;
            rdIdx_ff <= fidIdx;
            if (regRdStb && isCtrl) begin
                rdOther_ff <= ctrl_ff[subIdx];
            end else if (regRdStb && isMask) begin
                rdOther_ff <= mask_ff[subIdx];
            end else if (regRdStb && isStat) begin
                rdOther_ff <= {hitCount_ff, hitLast_ff};
            end else begin
                rdOther_ff <= 32'h00000000;
            end
        end
    end

    always @* begin
        if (rdFid_ff) begin
            regRdData = idRdData & `CAFC_FID_WMASK; // RULE8
            regRdData[`CAFC_EXTENDED_SELECT_BIT] = exSel_ff[rdIdx_ff];
        end else if (rdCtrl_ff) begin
            regRdData = rdOther_ff;
        end else begin
            regRdData = 32'h00000000;
        end
    end

    // Per-filter field extraction and match
    wire [NUM_FILT-1:0] filtHit;
    genvar f;
    generate
        for (f = 0; f < NUM_FILT; f = f + 1) begin : gFilt
            wire [7:0] lane = ctrl_ff[f/4][(f%4)*8 +: 8]; // RULE4 RULE11
            wire [31:0] idw = idWords[f*32 +: 32];
            wire [1:0] msel = lane[`CAFC_MSEL_HI:`CAFC_MSEL_LO];
            wire [31:0] msk = mask_ff[msel]; // RULE2
            wire [10:0] sidDiff = (rxStdId ^ idw[`CAFC_SID_HI:`CAFC_SID_LO])
                & msk[`CAFC_SID_HI:`CAFC_SID_LO]; // RULE5
            wire [17:0] eidDiff = (rxExtId ^ idw[`CAFC_EID_HI:`CAFC_EID_LO])
                & msk[`CAFC_EID_HI:`CAFC_EID_LO]; // RULE7
            wire idOk = (sidDiff == 11'h000) && (!rxExtended || eidDiff == 18'h00000);
            assign filtEn[f] = lane[`CAFC_EN_BIT];
            assign filtMsel[f*2 +: 2] = msel;
            assign filtFsel[f*FIFO_W +: FIFO_W] = lane[`CAFC_FSEL_HI:`CAFC_FSEL_LO];
            assign filtHit[f] = filtEn[f] // RULE1
                && (exSel_ff[f] == rxExtended) // RULE6
                && idOk; // RULE12
        end
    endgenerate

    // Lowest numbered hitting filter wins
    reg anyHit;
    reg [3:0] firstHit;
    integer k;
    always @* begin
        anyHit = 1'b0;
        firstHit = 4'h0;
        for (k = NUM_FILT - 1; k >= 0; k = k - 1) begin
            if (filtHit[k]) begin
                anyHit = 1'b1;
                firstHit = k[3:0];
            end
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            matchValid <= 1'b0;
            matchHit <= 1'b0;
            matchFilter <= 4'h0;
            matchFifo <= {FIFO_W{1'b0}};
            hitLast_ff <= {NUM_FILT{1'b0}};
            hitCount_ff <= 16'h0000;
        end else begin
            matchValid <= rxValid;
            if (rxValid) begin
                matchHit <= anyHit;
                matchFilter <= firstHit;
                matchFifo <= filtFsel[firstHit*FIFO_W +: FIFO_W]; // RULE3
                hitLast_ff <= filtHit;
                if (anyHit) begin
                    hitCount_ff <= hitCount_ff + 16'h0001;
                end
            end
        end
    end
endmodule

// ===== cafc_id_store.v
// Identifier store: sixteen filter identifier words, registered read port.
// Assumes writes are gated by the caller; holds no reset on identifier bits.
module cafc_id_store #(
    parameter NUM = 16,
    parameter IDX_W = 4
) (
    input wire clk_sys,
    input wire wrEn,
    input wire [IDX_W-1:0] wrIdx,
    input wire [31:0] wrData,
    input wire [IDX_W-1:0] rdIdx,
    output reg [31:0] rdData,
    output wire [NUM*32-1:0] allWords
);
    reg [31:0] mem_ff [0:NUM-1];
    genvar g;

    always @(posedge clk_sys) begin
        if (wrEn) begin
            mem_ff[wrIdx] <= wrData;
        end
        rdData <= mem_ff[rdIdx];
    end

    generate
        for (g = 0; g < NUM; g = g + 1) begin : gFlat
            assign allWords[g*32 +: 32] = mem_ff[g];
        end
    endgenerate
endmodule

// ===== tb_can_acceptance_filter_config.sv
// Bench for the acceptance filter top: register port and match path.
// Assumes the engine model and the bound monitor.
`include "cafc_consts.vh"
module tb_can_acceptance_filter_config;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0, arst_n = 1'h0, regWrStb = 1'h0, regRdStb = 1'h0, rdPend = 1'h0;
    logic [5:0] regAddr = 6'h00;
    logic [31:0] regWrData = 32'h0, regRdData, d;
    logic rxValid, rxExtended, matchValid, matchHit;
    logic [10:0] rxStdId;
    logic [17:0] rxExtId;
    logic [3:0] matchFilter;
    logic [4:0] matchFifo, f;
    logic [31:0] rdQ[$], mQ[$];
    int err_count = 0, tests_run = 0, seed = 80;
    cafc_filter_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .rxValid(rxValid), .rxExtended(rxExtended),
        .rxStdId(rxStdId), .rxExtId(rxExtId), .matchValid(matchValid),
        .matchHit(matchHit), .matchFilter(matchFilter), .matchFifo(matchFifo));
    cafc_engine_model u_eng (.clk_sys(clk_sys), .rxValid(rxValid),
        .rxExtended(rxExtended), .rxStdId(rxStdId), .rxExtId(rxExtId));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (err_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task bus(input logic w, input logic r, input logic [5:0] a, input logic [31:0] v);
        regWrStb <= w;
        regRdStb <= r;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk_sys);
    endtask
    task rd(input logic [5:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        bus(0, 1, a, 32'h0);
    endtask
    task rx(input logic e, input logic [10:0] s, input logic [17:0] x, input logic [9:0] r);
        mQ.push_back({22'h0, r});
        u_eng.send(1, e, s, x);
    endtask
    initial forever #25 clk_sys = ~clk_sys;
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        end_of_test;
    end
    always @(posedge clk_sys) rdPend <= regRdStb;
    always @(negedge clk_sys) begin
        if (rdPend) chk(regRdData, rdQ.pop_front());
        if (matchValid) chk({matchHit, matchFilter, matchFifo}, mQ.pop_front());
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) rd(i, 32'h0);
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            bus(1, 0, 6'h10 + i, d);
            rd(6'h10 + i, d & `CAFC_FID_WMASK);
        end
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            bus(1, 0, i, d);
            rd(i, d);
            bus(1, 0, i, 32'h0);
            bus(1, 0, 6'h04 + i, 32'hFFFFFFFF);
        end
        rd(6'h3F, 32'h0);
        bus(1, 0, 6'h19, 32'h24600000);
        for (int m = 0; m < 4; m++) begin
            f = (m == 3) ? 5'h1F : 5'(m * 10);
            bus(1, 0, 6'h04 + m, 32'h0);
            bus(1, 0, 6'h02, {16'h0, 1'h1, 2'(m), f, 8'h00});
            bus(0, 0, 6'h00, 32'h0);
            rx(0, 11'h0F0, 18'h0, {1'h1, 4'h9, f});
            rx(1, 11'h0F0, 18'h0, 10'h000);
            u_eng.send(0, 0, 11'h0, 18'h0);
            bus(1, 0, 6'h04 + m, 32'hFFFFFFFF);
        end
        bus(0, 0, 6'h00, 32'h0);
        rx(0, 11'h123, 18'h0, {1'h1, 4'h9, 5'h1F});
        rx(0, 11'h122, 18'h0, 10'h000);
        u_eng.send(0, 0, 11'h0, 18'h0);
        bus(1, 0, 6'h19, 32'h0);
        rd(6'h19, 32'h24600000);
        bus(1, 0, 6'h02, 32'h0);
        bus(0, 0, 6'h00, 32'h0);
        rx(0, 11'h123, 18'h0, 10'h000);
        u_eng.send(0, 0, 11'h0, 18'h0);
        bus(1, 0, 6'h19, 32'h246A5A5A);
        bus(1, 0, 6'h02, 32'h00008700);
        bus(0, 0, 6'h00, 32'h0);
        rx(1, 11'h123, 18'h25A5A, {1'h1, 4'h9, 5'h07});
        rx(0, 11'h123, 18'h25A5A, 10'h000);
        rx(1, 11'h123, 18'h25A5B, 10'h000);
        u_eng.send(0, 0, 11'h0, 18'h0);
        rd(6'h08, 32'h00060000);
        bus(0, 0, 6'h00, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk(rdQ.size() + mQ.size(), 32'h0);
        end_of_test;
    end
endmodule
